/* File: dv/bridge_sva.sv */
// Purpose: Port checks of the bridge
// Assumes: One clock, async low reset
// Notes: Bound into every bridge
`timescale 1ns/1ps
module bridge_sva (
  // Watched ports
  input wire logic clk, rst_n, s_awvalid, s_wvalid, s_awready, s_bvalid, s_arvalid, s_arready,
  input wire logic s_rvalid, s_rready, m_arvalid, m_arready, tx_valid, tx_ready, tx_last,
  input wire logic device_to_cpu_irq,
  input wire logic [31:0] m_araddr, tx_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Write taken, then answered a cycle on
  sequence wr_taken; s_awvalid && s_wvalid && !s_bvalid && !s_awready; endsequence
  sequence wr_answer; s_awready && s_bvalid; endsequence
  wr_answer_a: assert property (wr_taken |=> wr_answer) else $error("no write answer");
  rd_answer_a: assert property (s_arvalid && !s_arready && !s_rvalid |=> s_arready && s_rvalid)
    else $error("no read answer");
  rd_done_a: assert property (s_rvalid && s_rready |=> !s_rvalid) else $error("read held");
  ar_hold_a: assert property (m_arvalid && !m_arready |=> m_arvalid && $stable(m_araddr))
    else $error("request dropped");
  ar_align_a: assert property (m_arvalid |-> m_araddr[8:0] == 9'h000) else $error("unaligned");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("word dropped");
  // Irq follows the last word, then sticks until a write
  tx_irq_a: assert property (tx_valid && tx_ready && tx_last |-> ##[1:2] device_to_cpu_irq)
    else $error("no irq");
  irq_hold_a: assert property (device_to_cpu_irq |=> device_to_cpu_irq || s_awready) else $error("irq lost");
endmodule
bind transport_bridge bridge_sva chk (.*);

/* File: dv/mem_partner.sv */
// Purpose: Memory stand-in for the burst master
// Assumes: Writes dropped; each word is its byte address / 4
// Notes: Idle data inverted; answers at half rate
`timescale 1ns/1ps
module mem_partner (
  // Burst master side
  input wire logic clk, rst_n, m_arvalid, m_rready,
  input wire logic [31:0] m_araddr,
  output logic m_arready, m_rvalid, m_rlast, m_awready, m_wready, m_bvalid,
  output logic [255:0] m_rdata
);
  logic [31:0] addr_r;
  logic [4:0] left_r;
  logic gap_r;
  // One 16-beat burst at a time, gaps to force stalls
  assign m_arready = left_r == 5'h00 && gap_r;
  assign m_rvalid = left_r != 5'h00 && !gap_r;
  assign m_rlast = m_rvalid && left_r == 5'h01;
  for (genvar k = 0; k < 8; k++) begin : g_word
    assign m_rdata[32*k+:32] = {32{!m_rvalid}} ^ ((addr_r >> 2) + 32'(k));
  end
  // Writes taken at once; response always standing
  assign {m_awready, m_wready, m_bvalid} = 3'b111;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {addr_r, left_r, gap_r} <= '0;
    end else begin
      gap_r <= !gap_r;
      if (m_arvalid && m_arready) begin
        {addr_r, left_r} <= {m_araddr, 5'h10};
      end else if (m_rvalid && m_rready) begin
        {addr_r, left_r} <= {addr_r + 32'h20, left_r - 5'h01};
      end
    end
  end
endmodule

/* File: dv/test_transport_bridge.sv */
// Purpose: Self-checking bench of the bridge
// Assumes: Short receive frame
// Notes: Payload word n is 0x100 + n; a data frame's header word comes first
`timescale 1ns/1ps
module test_transport_bridge;
  logic clk = 0, rst_n = 0, s_awvalid = 0, s_wvalid = 0, s_arvalid = 0, s_bready = 1, s_rready = 1;
  logic tx_ready = 1, rx_valid = 0, rx_last = 0, link_error_valid = 0, s_awready, s_wready, s_bvalid;
  logic s_arready, s_rvalid, m_arvalid, m_rready, m_awvalid, m_wlast, m_wvalid, m_bready, tx_valid;
  logic tx_last, rx_ready, device_to_cpu_irq, cpu_receive_irq, m_arready, m_rvalid, m_rlast, m_awready;
  logic m_wready, m_bvalid;
  logic [31:0] s_awaddr = 0, s_wdata = 0, s_araddr = 0, rx_data = 0, link_error = 0;
  logic [31:0] s_rdata, m_araddr, m_awaddr, tx_data, rdat;
  logic [3:0] s_wstrb = 4'hf;
  logic [1:0] s_bresp, s_rresp, rrsp;
  logic [7:0] m_arlen, m_awlen;
  logic [255:0] m_rdata, m_wdata;
  logic [6:0] rows [6] = '{{5'h00, 2'h0}, {5'h08, 2'h0}, {5'h0c, 2'h0}, {5'h10, 2'h0}, {5'h14, 2'h2}, {5'h02, 2'h2}};
  int bad_count = 0, checked = 0;
  transport_bridge dut (.*);
  mem_partner mem (.*);
  always #12.5 clk = ~clk;
  task automatic check(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic test_done;
    $display("checks %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // One bus cycle; request held until ready is seen
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int i;
    {s_awaddr, s_araddr, s_wdata} = {27'h0, a, 27'h0, a, d};
    {s_awvalid, s_wvalid, s_arvalid} = {w, w, !w};
    for (i = 0; i < 20 && !(w ? s_awready : s_arready); i++) @(posedge clk);
    {rdat, rrsp} = {s_rdata, s_rresp};
    #1 {s_awvalid, s_wvalid, s_arvalid} = 3'b000;
    #25 if (i == 20) begin
      check(1'b0, "bus hang");
      test_done;
    end
  endtask
  // Start a frame, collect it under link stalls, then ack
  task automatic xmit(input logic df, input int cnt);
    int i, n, w;
    w = cnt + df;
    n = 0;
    tx_ready = 0;
    bus(1'b1, bridge_pkg::OFS_CMD, {2'b01, df, 13'h0, cnt[15:0]});
    for (i = 0; i < 4000 && n < w; i++) begin
      @(posedge clk);
      if (tx_valid && tx_ready) begin
        check(tx_data === (df && n == 0 ? bridge_pkg::DATA_HDR : 32'h100 + n - df), "tx word");
        check(tx_last === (n == w - 1), "tx last");
        n++;
      end
      #1 tx_ready = i % 3 != 0;
    end
    check(n == w, "tx hang");
    if (n != w) test_done;
    repeat (3) @(posedge clk);
    check(device_to_cpu_irq === 1'b1, "no irq");
    #1 bus(1'b1, bridge_pkg::OFS_ACK, 32'h8000_0000);
    check(device_to_cpu_irq === 1'b0, "irq kept");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1 rst_n = 1;
    #50;
    foreach (rows[k]) begin
      bus(1'b0, rows[k][6:2], 32'h0);
      check(rrsp === rows[k][1:0] && (rrsp !== 2'h0 || rdat === 32'h0), "read row");
    end
    $display("register reads done");
    {link_error, link_error_valid} = {32'h0000_00a5, 1'b1};
    #25 link_error_valid = 0;
    bus(1'b0, bridge_pkg::OFS_ERR_NDBASE, 32'h0);
    check(rdat === 32'h0000_00a5, "error code");
    bus(1'b1, bridge_pkg::OFS_TX_BASE, 32'h0000_0400);
    xmit(1'b1, 130);
    xmit(1'b0, 3);
    {rx_data, rx_last, rx_valid} = {32'h27, 2'b11};
    @(posedge clk) #1 rx_valid = 0;
    for (int i = 0; i < 400 && !cpu_receive_irq; i++) @(posedge clk);
    check(cpu_receive_irq === 1'b1, "no rx irq");
    if (!cpu_receive_irq) test_done;
    #1 bus(1'b0, bridge_pkg::OFS_CNT_PLBASE, 32'h0);
    check(rdat === 32'h8000_0001, "rx count");
    bus(1'b1, bridge_pkg::OFS_ACK, 32'h6000_0000);
    bus(1'b1, bridge_pkg::OFS_CMD, 32'h8000_0000);
    bus(1'b0, bridge_pkg::OFS_CNT_PLBASE, 32'h0);
    check(rdat === 32'h0 && cpu_receive_irq === 1'b0, "rx clear");
    $display("transfers done");
    test_done;
  end
endmodule

/* File: rtl/bridge_pkg.sv */
// Purpose: Shared constants of the memory-to-link transport bridge
// Assumes: 32-bit register bus, 256-bit memory bus, 32-bit link words
// Notes: Offsets are byte addresses on the register bus
package bridge_pkg;
  // Register offsets (read and write maps overlap)
  localparam logic [4:0] OFS_TX_BASE = 5'h00;
  localparam logic [4:0] OFS_ERR_NDBASE = 5'h04;
  localparam logic [4:0] OFS_CMD = 5'h08;
  localparam logic [4:0] OFS_CNT_PLBASE = 5'h0c;
  localparam logic [4:0] OFS_ACK = 5'h10;
  // Command fields
  localparam int CMD_HWRST = 31;
  localparam int CMD_START = 30;
  localparam int CMD_DATA = 29;
  localparam int CMD_CNT_W = 16;
  // Acknowledge fields
  localparam int ACK_DEV = 31;
  localparam int ACK_RCV = 30;
  localparam int ACK_KIND = 29;
  // Received count fields
  localparam int CNT_KIND = 31;
  localparam int CNT_W = 24;
  // Memory burst shape: 16 beats of 256 bits
  localparam logic [7:0] BURST_LEN = 8'h0f;
  localparam logic [4:0] BURST_BEATS = 5'h10;
  localparam logic [6:0] BURST_WORDS_M1 = 7'h7f;
  localparam logic [16:0] BURST_WORDS = 17'h00080;
  localparam logic [31:0] BURST_BYTES = 32'h0000_0200;
  // Frame header
  localparam logic [7:0] FRAME_TYPE_DATA = 8'h46;
  localparam logic [31:0] DATA_HDR = 32'h0000_0046;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: rtl/receive_width_fifo.sv */
// Purpose: Narrow-in, wide-out FIFO for the receive path
// Assumes: Writer stops when in_ready falls; one word of slack
// Notes: Only whole entries are visible on the wide side
`timescale 1ns/1ps
module receive_width_fifo #(
  parameter int WIDE = 256,
  parameter int NARROW = 32,
  parameter int ALOG = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  // Narrow side
  input wire logic [NARROW-1:0] in_data,
  input wire logic in_push,
  output logic in_ready,
  // Wide side
  output logic [WIDE-1:0] out_data,
  input wire logic out_pop,
  output logic [ALOG:0] count
);
  localparam int RATIO = WIDE / NARROW;
  localparam int SW = $clog2(RATIO);
  localparam logic [ALOG:0] RDY_LVL = (ALOG+1)'(2**ALOG - 2);
  logic [WIDE-1:0] mem [2**ALOG];
  logic [WIDE-1:0] acc_r;
  logic [ALOG:0] wp_r, rp_r;
  logic [SW-1:0] sub_r;
  logic done;

  // Two entries of slack cover the registered ready upstream
  assign count = wp_r - rp_r;
  assign in_ready = (count <= RDY_LVL);
  assign out_data = mem[rp_r[ALOG-1:0]];
  assign done = in_push && (sub_r == SW'(RATIO - 1));

  // Gather words, commit a full entry
  always_ff @(posedge clk) begin
    if (in_push) begin
      acc_r[sub_r*NARROW +: NARROW] <= in_data;
    end
    if (done) begin
      mem[wp_r[ALOG-1:0]] <= {in_data, acc_r[WIDE-NARROW-1:0]};
    end
  end

  // Pointers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      sub_r <= '0;
    end else if (clr) begin
      wp_r <= '0;
      rp_r <= '0;
      sub_r <= '0;
    end else begin
      if (in_push) begin
        sub_r <= sub_r + 1'b1;
      end
      if (done) begin
        wp_r <= wp_r + 1'b1;
      end
      if (out_pop) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end
endmodule

/* File: rtl/transmit_width_fifo.sv */
// Purpose: Wide-in, narrow-out FIFO for the transmit path
// Assumes: Writer checks almost_full before a whole burst
// Notes: Word 0 of an entry is its low 32 bits
`timescale 1ns/1ps
module transmit_width_fifo #(
  parameter int WIDE = 256,
  parameter int NARROW = 32,
  parameter int ALOG = 5,
  parameter int AF_ROOM = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  // Wide side
  input wire logic [WIDE-1:0] in_data,
  input wire logic in_push,
  output logic almost_full,
  // Narrow side
  output logic [NARROW-1:0] out_data,
  input wire logic out_pop,
  output logic empty
);
  localparam int RATIO = WIDE / NARROW;
  localparam int SW = $clog2(RATIO);
  localparam logic [ALOG:0] AF_LVL = (ALOG+1)'(2**ALOG - AF_ROOM);
  logic [WIDE-1:0] mem [2**ALOG];
  logic [ALOG:0] wp_r, rp_r;
  logic [SW-1:0] sub_r;
  logic [ALOG:0] fill;

  // Free room below one burst counts as almost full
  assign fill = wp_r - rp_r;
  assign empty = (fill == '0);
  assign almost_full = (fill > AF_LVL);
  assign out_data = mem[rp_r[ALOG-1:0]][sub_r*NARROW +: NARROW];

  // Storage, no reset needed on data
  always_ff @(posedge clk) begin
    if (in_push) begin
      mem[wp_r[ALOG-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      sub_r <= '0;
    end else if (clr) begin
      wp_r <= '0;
      rp_r <= '0;
      sub_r <= '0;
    end else begin
      if (in_push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (out_pop) begin
        sub_r <= sub_r + 1'b1;
        if (sub_r == SW'(RATIO - 1)) begin
          rp_r <= rp_r + 1'b1;
        end
      end
    end
  end
endmodule

/* File: rtl/transport_bridge.sv */
// Purpose: Moves frames between memory and the link-layer core
// Assumes: Link core and both buses share clk
// Notes: Register bus is a lite slave; memory side a burst master
//
// Behaviour
// - Offset 0x00 sets transmit area base
// - Offset 0x04 sets non-data receive base
// - Offset 0x0C sets payload receive base
// - Command bit 31 resets, bit 30 starts
// - Bit 29 picks frame kind; low 16 count
// - Any command write clears received count
// - Offset 0x0C reads received word total
// - Count bit 31 gives kind; ack clears
// - Ack bits 31 and 30 clear interrupts
// - Offset 0x04 reads link error code
// - Non-data and payload go to separate regions
// - Five channel groups; address from state machines
// - Each direction buffered in width FIFO
// - Read requests continue until count reached
// - No read request while FIFO almost full
// - Pop when FIFO has data, link ready
// - Data frames get header word prepended
// - End-of-packet marks the final word
// - Receive header type steers destination region
// - Data frame header stripped before storing
// - Fixed 16-beat bursts; pad short packets
// - Write machine waits for full burst
`timescale 1ns/1ps
module transport_bridge #(
  parameter int ALOG = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register bus, write
  input wire logic [31:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // Register bus, read
  input wire logic [31:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Memory read address and data groups
  output logic [31:0] m_araddr,
  output logic [7:0] m_arlen,
  output logic m_arvalid,
  input wire logic m_arready,
  input wire logic [255:0] m_rdata,
  input wire logic m_rvalid,
  input wire logic m_rlast,
  output logic m_rready,
  // Memory write address, data and response groups
  output logic [31:0] m_awaddr,
  output logic [7:0] m_awlen,
  output logic m_awvalid,
  input wire logic m_awready,
  output logic [255:0] m_wdata,
  output logic m_wlast,
  output logic m_wvalid,
  input wire logic m_wready,
  input wire logic m_bvalid,
  output logic m_bready,
  // Link transmit
  output logic [31:0] tx_data,
  output logic tx_valid,
  output logic tx_last,
  input wire logic tx_ready,
  // Link receive
  input wire logic [31:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_last,
  output logic rx_ready,
  // Link status
  input wire logic [31:0] link_error,
  input wire logic link_error_valid,
  // Interrupts
  output logic device_to_cpu_irq,
  output logic cpu_receive_irq
);
  typedef enum {RD_IDLE, RD_ADDR, RD_DATA} rd_state_t;
  typedef enum {WR_IDLE, WR_ADDR, WR_DATA, WR_RESP} wr_state_t;
  typedef enum {RX_HDR, RX_BODY, RX_PAD, RX_FLUSH} rx_state_t;

  rd_state_t rd_r;
  wr_state_t wr_r;
  rx_state_t rx_r;
  logic s_awready_r, s_bvalid_r, s_arready_r, s_rvalid_r;
  logic [1:0] s_bresp_r, s_rresp_r;
  logic [31:0] s_rdata_r;
  logic [31:0] tx_base_r, nd_base_r, pl_base_r, err_r;
  logic [bridge_pkg::CMD_CNT_W-1:0] tx_cnt_r, sent_r;
  logic [16:0] req_r;
  logic tx_busy_r, hdr_pend_r, tx_drain_r, flush_tx_r;
  logic [31:0] tx_data_r;
  logic tx_valid_r, tx_last_r;
  logic [31:0] rd_addr_r, m_araddr_r, wr_addr_r, m_awaddr_r;
  logic m_arvalid_r, m_awvalid_r, m_wvalid_r, m_wlast_r;
  logic [255:0] m_wdata_r;
  logic [3:0] beat_r;
  logic [bridge_pkg::CNT_W-1:0] rx_cnt_r;
  logic [6:0] pkt_r;
  logic kind_nd_r, kind_flag_r, rx_ready_r;
  logic dev_irq_r, rcv_irq_r;
  logic wr_go, rd_go, cmd_wr, ack_wr, hw_rst;
  logic tx_af, tx_empty, tx_load, tx_pop, tx_done, rx_acc;
  logic [31:0] tx_word;
  logic rxf_ready, rxf_push, rxf_pop;
  logic [31:0] rxf_word;
  logic [255:0] rxf_out;
  logic [ALOG:0] rxf_cnt;

  // Low address bits select the register; aligned words only
  function automatic logic hit(input logic [31:0] a, input logic [4:0] ofs);
    hit = (a[4:0] == ofs);
  endfunction

  // Byte-lane merge for stored registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // Write handshake: address and data taken together
  assign wr_go = s_awvalid && s_wvalid && !s_awready_r && !s_bvalid_r;
  assign rd_go = s_arvalid && !s_arready_r && !s_rvalid_r;
  assign cmd_wr = wr_go && hit(s_awaddr, bridge_pkg::OFS_CMD);
  assign ack_wr = wr_go && hit(s_awaddr, bridge_pkg::OFS_ACK);
  assign hw_rst = cmd_wr && s_wdata[bridge_pkg::CMD_HWRST];

  // Register bus handshakes and responses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_awready_r <= 1'b0;
      s_bvalid_r <= 1'b0;
      s_bresp_r <= bridge_pkg::RESP_OKAY;
      s_arready_r <= 1'b0;
      s_rvalid_r <= 1'b0;
      s_rresp_r <= bridge_pkg::RESP_OKAY;
      s_rdata_r <= '0;
    end else begin
      s_awready_r <= wr_go;
      if (wr_go) begin
        s_bvalid_r <= 1'b1;
        s_bresp_r <= (s_awaddr[4:0] > bridge_pkg::OFS_ACK || s_awaddr[1:0] != 2'h0) ?
                     bridge_pkg::RESP_SLVERR : bridge_pkg::RESP_OKAY;
      end else if (s_bready) begin
        s_bvalid_r <= 1'b0;
      end
      s_arready_r <= rd_go;
      if (rd_go) begin
        s_rvalid_r <= 1'b1;
        s_rresp_r <= bridge_pkg::RESP_OKAY;
        s_rdata_r <= '0;
        if (hit(s_araddr, bridge_pkg::OFS_ERR_NDBASE)) begin
          s_rdata_r <= err_r;
        end else if (hit(s_araddr, bridge_pkg::OFS_CNT_PLBASE)) begin
          s_rdata_r[bridge_pkg::CNT_W-1:0] <= rx_cnt_r;
          s_rdata_r[bridge_pkg::CNT_KIND] <= kind_flag_r;
        end else if (s_araddr[4:0] > bridge_pkg::OFS_ACK || s_araddr[1:0] != 2'h0) begin
          s_rresp_r <= bridge_pkg::RESP_SLVERR;
        end
      end else if (s_rready) begin
        s_rvalid_r <= 1'b0;
      end
    end
  end

  // Base addresses; low nine bits are software's to keep zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_base_r <= '0;
      nd_base_r <= '0;
      pl_base_r <= '0;
    end else if (wr_go) begin
      if (hit(s_awaddr, bridge_pkg::OFS_TX_BASE)) begin
        tx_base_r <= merge(tx_base_r, s_wdata, s_wstrb);
      end
      if (hit(s_awaddr, bridge_pkg::OFS_ERR_NDBASE)) begin
        nd_base_r <= merge(nd_base_r, s_wdata, s_wstrb);
      end
      if (hit(s_awaddr, bridge_pkg::OFS_CNT_PLBASE)) begin
        pl_base_r <= merge(pl_base_r, s_wdata, s_wstrb);
      end
    end
  end

  // Last error code reported by the link core
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_r <= '0;
    end else if (link_error_valid) begin
      err_r <= link_error;
    end
  end

  // Transmit command and frame sequencing
  assign tx_load = !tx_valid_r || tx_ready;
  assign tx_pop = tx_busy_r && !hdr_pend_r && !tx_empty && tx_load && sent_r != tx_cnt_r;
  assign tx_done = tx_valid_r && tx_ready && tx_last_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_busy_r <= 1'b0;
      hdr_pend_r <= 1'b0;
      tx_cnt_r <= '0;
      sent_r <= '0;
      tx_drain_r <= 1'b0;
      flush_tx_r <= 1'b0;
    end else if (hw_rst) begin
      tx_busy_r <= 1'b0;
      hdr_pend_r <= 1'b0;
      tx_drain_r <= 1'b0;
      flush_tx_r <= 1'b1;
    end else begin
      flush_tx_r <= 1'b0;
      if (cmd_wr && s_wdata[bridge_pkg::CMD_START] && !tx_busy_r) begin
        tx_cnt_r <= s_wdata[bridge_pkg::CMD_CNT_W-1:0];
        hdr_pend_r <= s_wdata[bridge_pkg::CMD_DATA];
        tx_busy_r <= s_wdata[bridge_pkg::CMD_DATA] || s_wdata[bridge_pkg::CMD_CNT_W-1:0] != '0;
        sent_r <= '0;
      end else begin
        if (tx_busy_r && hdr_pend_r && tx_load) begin
          hdr_pend_r <= 1'b0;
        end
        if (tx_pop) begin
          sent_r <= sent_r + 1'b1;
        end
        if (tx_done) begin
          tx_busy_r <= 1'b0;
          tx_drain_r <= 1'b1;
        end
        // Surplus words of the last burst are dropped once reads settle
        if (tx_drain_r && rd_r == RD_IDLE) begin
          tx_drain_r <= 1'b0;
          flush_tx_r <= 1'b1;
        end
      end
    end
  end

  // Registered link transmit stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_data_r <= '0;
      tx_valid_r <= 1'b0;
      tx_last_r <= 1'b0;
    end else if (hw_rst) begin
      tx_valid_r <= 1'b0;
      tx_last_r <= 1'b0;
    end else if (tx_load) begin
      tx_valid_r <= 1'b0;
      tx_last_r <= 1'b0;
      if (tx_busy_r && hdr_pend_r) begin
        tx_data_r <= bridge_pkg::DATA_HDR;
        tx_valid_r <= 1'b1;
        tx_last_r <= (tx_cnt_r == '0);
      end else if (tx_pop) begin
        tx_data_r <= tx_word;
        tx_valid_r <= 1'b1;
        tx_last_r <= (sent_r == tx_cnt_r - 1'b1);
      end
    end
  end

  // Read address machine fills the transmit FIFO a burst at a time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_r <= RD_IDLE;
      req_r <= '0;
      rd_addr_r <= '0;
      m_araddr_r <= '0;
      m_arvalid_r <= 1'b0;
    end else if (hw_rst) begin
      rd_r <= RD_IDLE;
      m_arvalid_r <= 1'b0;
    end else if (cmd_wr && s_wdata[bridge_pkg::CMD_START] && !tx_busy_r) begin
      req_r <= '0;
      rd_addr_r <= tx_base_r;
    end else begin
      case (rd_r)
        RD_IDLE: begin
          if (tx_busy_r && req_r < {1'b0, tx_cnt_r} && !tx_af) begin
            m_araddr_r <= rd_addr_r;
            m_arvalid_r <= 1'b1;
            rd_r <= RD_ADDR;
          end
        end
        RD_ADDR: begin
          if (m_arready) begin
            m_arvalid_r <= 1'b0;
            req_r <= req_r + bridge_pkg::BURST_WORDS;
            rd_addr_r <= rd_addr_r + bridge_pkg::BURST_BYTES;
            rd_r <= RD_DATA;
          end
        end
        RD_DATA: begin
          if (m_rvalid && m_rlast) begin
            rd_r <= RD_IDLE;
          end
        end
        default: rd_r <= RD_IDLE;
      endcase
    end
  end

  transmit_width_fifo #(.WIDE(256), .NARROW(32), .ALOG(ALOG), .AF_ROOM(16)) u_txf (
    .clk(clk),
    .rst_n(rst_n),
    .clr(flush_tx_r),
    .in_data(m_rdata),
    .in_push(m_rvalid && rd_r == RD_DATA),
    .almost_full(tx_af),
    .out_data(tx_word),
    .out_pop(tx_pop),
    .empty(tx_empty)
  );

  // Receive framing: steer, strip header, pad to whole bursts
  assign rx_acc = rx_valid && rx_ready_r;
  always_comb begin
    rxf_push = 1'b0;
    rxf_word = rx_data;
    if (rx_r == RX_PAD) begin
      rxf_push = rxf_ready && pkt_r != '0;
      rxf_word = '0;
    end else if (rx_acc) begin
      rxf_push = !(rx_r == RX_HDR && rx_data[7:0] == bridge_pkg::FRAME_TYPE_DATA);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_r <= RX_HDR;
      rx_cnt_r <= '0;
      pkt_r <= '0;
      kind_nd_r <= 1'b0;
      rx_ready_r <= 1'b0;
    end else if (hw_rst) begin
      rx_r <= RX_HDR;
      rx_cnt_r <= '0;
      pkt_r <= '0;
      rx_ready_r <= 1'b0;
    end else begin
      rx_ready_r <= (rx_r == RX_HDR || rx_r == RX_BODY) && rxf_ready && !(rx_acc && rx_last);
      if (cmd_wr) begin
        rx_cnt_r <= '0;
      end else if (rx_acc) begin
        rx_cnt_r <= rx_cnt_r + 1'b1;
      end
      if (rxf_push) begin
        pkt_r <= pkt_r + 1'b1;
      end
      case (rx_r)
        RX_HDR: begin
          if (rx_acc) begin
            kind_nd_r <= rx_data[7:0] != bridge_pkg::FRAME_TYPE_DATA;
            rx_r <= rx_last ? RX_PAD : RX_BODY;
          end
        end
        RX_BODY: begin
          if (rx_acc && rx_last) begin
            rx_r <= RX_PAD;
          end
        end
        RX_PAD: begin
          if (pkt_r == '0 || (rxf_push && pkt_r == bridge_pkg::BURST_WORDS_M1)) begin
            rx_r <= RX_FLUSH;
          end
        end
        RX_FLUSH: begin
          if (rxf_cnt == '0 && wr_r == WR_IDLE) begin
            rx_r <= RX_HDR;
          end
        end
        default: rx_r <= RX_HDR;
      endcase
    end
  end

  receive_width_fifo #(.WIDE(256), .NARROW(32), .ALOG(ALOG)) u_rxf (
    .clk(clk),
    .rst_n(rst_n),
    .clr(hw_rst),
    .in_data(rxf_word),
    .in_push(rxf_push),
    .in_ready(rxf_ready),
    .out_data(rxf_out),
    .out_pop(rxf_pop),
    .count(rxf_cnt)
  );

  // Write machine: one full burst per request
  assign rxf_pop = (wr_r == WR_ADDR && m_awready) || (wr_r == WR_DATA && m_wready && !m_wlast_r);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r <= WR_IDLE;
      wr_addr_r <= '0;
      m_awaddr_r <= '0;
      m_awvalid_r <= 1'b0;
      m_wvalid_r <= 1'b0;
      m_wlast_r <= 1'b0;
      m_wdata_r <= '0;
      beat_r <= '0;
    end else if (hw_rst) begin
      wr_r <= WR_IDLE;
      m_awvalid_r <= 1'b0;
      m_wvalid_r <= 1'b0;
      m_wlast_r <= 1'b0;
    end else begin
      if (rx_r == RX_HDR && rx_acc) begin
        wr_addr_r <= (rx_data[7:0] == bridge_pkg::FRAME_TYPE_DATA) ? pl_base_r : nd_base_r;
      end
      case (wr_r)
        WR_IDLE: begin
          if (rxf_cnt >= (ALOG+1)'(bridge_pkg::BURST_BEATS)) begin
            m_awaddr_r <= wr_addr_r;
            m_awvalid_r <= 1'b1;
            wr_r <= WR_ADDR;
          end
        end
        WR_ADDR: begin
          if (m_awready) begin
            m_awvalid_r <= 1'b0;
            m_wdata_r <= rxf_out;
            m_wvalid_r <= 1'b1;
            m_wlast_r <= 1'b0;
            beat_r <= '0;
            wr_r <= WR_DATA;
          end
        end
        WR_DATA: begin
          if (m_wready) begin
            if (m_wlast_r) begin
              m_wvalid_r <= 1'b0;
              m_wlast_r <= 1'b0;
              wr_r <= WR_RESP;
            end else begin
              m_wdata_r <= rxf_out;
              beat_r <= beat_r + 1'b1;
              m_wlast_r <= (beat_r == bridge_pkg::BURST_LEN[3:0] - 4'h1);
            end
          end
        end
        WR_RESP: begin
          if (m_bvalid) begin
            wr_addr_r <= wr_addr_r + bridge_pkg::BURST_BYTES;
            wr_r <= WR_IDLE;
          end
        end
        default: wr_r <= WR_IDLE;
      endcase
    end
  end

  // Sticky interrupts and frame kind; a new event beats a clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dev_irq_r <= 1'b0;
      rcv_irq_r <= 1'b0;
      kind_flag_r <= 1'b0;
    end else if (hw_rst) begin
      kind_flag_r <= 1'b0;
    end else begin
      if (tx_done || (cmd_wr && s_wdata[bridge_pkg::CMD_START] && !tx_busy_r &&
          !s_wdata[bridge_pkg::CMD_DATA] && s_wdata[bridge_pkg::CMD_CNT_W-1:0] == '0)) begin
        dev_irq_r <= 1'b1;
      end else if (ack_wr && s_wdata[bridge_pkg::ACK_DEV]) begin
        dev_irq_r <= 1'b0;
      end
      if (rx_r == RX_FLUSH && rxf_cnt == '0 && wr_r == WR_IDLE) begin
        rcv_irq_r <= 1'b1;
        kind_flag_r <= kind_nd_r;
      end else begin
        if (ack_wr && s_wdata[bridge_pkg::ACK_RCV]) begin
          rcv_irq_r <= 1'b0;
        end
        if (ack_wr && s_wdata[bridge_pkg::ACK_KIND]) begin
          kind_flag_r <= 1'b0;
        end
      end
    end
  end

  // Fixed bus qualifiers held in flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      m_arlen <= bridge_pkg::BURST_LEN;
      m_awlen <= bridge_pkg::BURST_LEN;
      m_rready <= 1'b0;
      m_bready <= 1'b0;
    end else begin
      m_rready <= 1'b1; // Room reserved by the almost-full check
      m_bready <= 1'b1;
    end
  end

  assign s_awready = s_awready_r;
  assign s_wready = s_awready_r;
  assign s_bvalid = s_bvalid_r;
  assign s_bresp = s_bresp_r;
  assign s_arready = s_arready_r;
  assign s_rvalid = s_rvalid_r;
  assign s_rresp = s_rresp_r;
  assign s_rdata = s_rdata_r;
  assign m_araddr = m_araddr_r;
  assign m_arvalid = m_arvalid_r;
  assign m_awaddr = m_awaddr_r;
  assign m_awvalid = m_awvalid_r;
  assign m_wdata = m_wdata_r;
  assign m_wvalid = m_wvalid_r;
  assign m_wlast = m_wlast_r;
  assign tx_data = tx_data_r;
  assign tx_valid = tx_valid_r;
  assign tx_last = tx_last_r;
  assign rx_ready = rx_ready_r;
  assign device_to_cpu_irq = dev_irq_r;
  assign cpu_receive_irq = rcv_irq_r;
endmodule
